// ### core/term_consts.svh
// Offsets, burst codes, window lengths, reset values and latency constants for the termination control.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TERM_CONSTS_SVH
`define TERM_CONSTS_SVH

`define ADDR_W          12
`define DATA_W          32
`define REG_CFG_FIELDS  12'h000
`define REG_CFG_LAT     12'h004
`define REG_STATUS      12'h008
`define CFG_FIELDS_RST  32'h0000_0000
`define CFG_LAT_RST     32'h0000_0009
`define PIPE_DEPTH      64
`define MAX_LAT         6'h3F
`define SUB_PRE1        7'h02
`define SUB_PRE2        7'h03
`define SUB_READ        7'h02
`define WIN_CHOP_PRE1   4'h4
`define WIN_CHOP_PRE2   4'h5
`define WIN_FULL_PRE1   4'h6
`define WIN_FULL_PRE2   4'h7
`define WIN_CRC_PRE1    4'h7
`define WIN_CRC_PRE2    4'h8
`define BURST_BL8       2'h0
`define BURST_OTF       2'h1
`define BURST_BC4       2'h2

`endif

// ### core/term_pkg.sv
// Types for the termination control: mode fields, latency fields and the state record.
// Assumes term_consts.svh is on the include path.
`include "term_consts.svh"

package term_pkg;

	typedef enum logic [1:0] {
		TERM_OFF,
		TERM_WRITE,
		TERM_NOMINAL,
		TERM_PARK
	} term_state_t;

	// Bit layout of the field register, high bit first
	typedef struct packed {
		logic [16:0] unused;
		logic        x8_part;
		logic        strobe_en;
		logic [1:0]  burst_mode;
		logic        write_crc;
		logic        preamble_2;
		logic [2:0]  park_sel;
		logic [2:0]  write_sel;
		logic [2:0]  nominal_sel;
	} cfg_fields_t;

	typedef struct packed {
		logic [16:0] unused;
		logic [3:0]  parity_lat;
		logic [5:0]  additive_lat;
		logic [4:0]  write_lat;
	} cfg_lat_t;

	typedef struct packed {
		logic                       pready;
		logic                       pslverr;
		logic [`DATA_W-1:0]         prdata;
		cfg_fields_t                fields;
		cfg_lat_t                   lat;
		logic [`PIPE_DEPTH-1:0]     pin_pipe;
		logic [`PIPE_DEPTH-1:0]     wr_pipe;
		logic [`PIPE_DEPTH-1:0]     wr_chop_pipe;
		logic [`PIPE_DEPTH-1:0]     rd_pipe;
		logic [3:0]                 wr_cnt;
		logic [3:0]                 rd_cnt;
		term_state_t                state;
		logic [2:0]                 code;
		logic                       strobe_term;
		logic                       pin_rx_en;
		logic                       active;
	} term_reg_t;

endpackage

// ### core/term_ctrl.sv
// On-die termination control with an APB register slave.
// Assumes commands and the termination pin are already decoded and synchronous to clk_i.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "term_consts.svh"

module term_ctrl
	import term_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [`ADDR_W-1:0]  paddr_i,
	input  wire logic [`DATA_W-1:0]  pwdata_i,
	output logic      [`DATA_W-1:0]  prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	input  wire logic                odt_i,
	input  wire logic                write_cmd_i,
	input  wire logic                read_cmd_i,
	input  wire logic                chop_i,
	input  wire logic                self_refresh_i,
	input  wire logic                dll_locked_i,
	output term_state_t              term_state_o,
	output logic      [2:0]          term_code_o,
	output logic                     term_active_o,
	output logic                     strobe_term_o,
	output logic                     pin_rx_en_o
);

	term_reg_t s;
	term_reg_t next_s;

	logic [6:0] wl;
	logic [6:0] sub_direct;
	logic [5:0] direct_lat;
	logic [5:0] read_off_lat;
	logic [5:0] nom_idx;
	logic [5:0] cnw_idx;
	logic [5:0] rd_idx;
	logic       nom_en;
	logic       wr_en;
	logic       park_en;
	logic       any_en;
	logic       rx_on;
	logic       nom_tap;
	logic       wr_tap;
	logic       wr_tap_chop;
	logic       rd_tap;
	logic [3:0] wr_win;
	logic [3:0] rd_win;
	logic       wr_active;
	logic       rd_active;
	logic       cmd_chop;
	logic       apb_access;

	function automatic logic [5:0] clamp_lat(input logic [6:0] total, input logic [6:0] sub);
		logic [6:0] diff;
		diff = total - sub;
		if (total <= sub)
			clamp_lat = 6'h01;
		else if (diff > 7'(`MAX_LAT))
			clamp_lat = `MAX_LAT;
		else
			clamp_lat = diff[5:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Latencies recomputed from the live fields

	assign wl           = 7'(s.lat.write_lat) + 7'(s.lat.additive_lat) + 7'(s.lat.parity_lat);
	assign sub_direct   = s.fields.preamble_2 ? `SUB_PRE2 : `SUB_PRE1;
	assign direct_lat   = clamp_lat(wl, sub_direct);
	assign read_off_lat = clamp_lat(wl, `SUB_READ);
	assign nom_idx      = dll_locked_i ? direct_lat - 6'h01 : 6'h00;
	assign cnw_idx      = direct_lat - 6'h01;
	assign rd_idx       = read_off_lat - 6'h01;

	assign nom_en  = s.fields.nominal_sel != 3'h0;
	assign wr_en   = s.fields.write_sel != 3'h0;
	assign park_en = s.fields.park_sel != 3'h0;
	assign any_en  = nom_en || wr_en || park_en;
	assign rx_on   = nom_en && !self_refresh_i;

	assign nom_tap     = s.pin_pipe[nom_idx];
	assign wr_tap      = s.wr_pipe[cnw_idx];
	assign wr_tap_chop = s.wr_chop_pipe[cnw_idx];
	assign rd_tap      = s.rd_pipe[rd_idx];

	assign cmd_chop = (s.fields.burst_mode == `BURST_BC4)
		|| ((s.fields.burst_mode == `BURST_OTF) && chop_i);

	// Write window length: CRC lengthens it, chop shortens it only when CRC is off
	always_comb
	begin
		if (s.fields.write_crc)
			wr_win = s.fields.preamble_2 ? `WIN_CRC_PRE2 : `WIN_CRC_PRE1;
		else if (wr_tap_chop)
			wr_win = s.fields.preamble_2 ? `WIN_CHOP_PRE2 : `WIN_CHOP_PRE1;
		else
			wr_win = s.fields.preamble_2 ? `WIN_FULL_PRE2 : `WIN_FULL_PRE1;
	end

	// Read window: park returns after turn-off latency plus this
	always_comb
	begin
		if (s.fields.burst_mode == `BURST_BC4)
			rd_win = s.fields.preamble_2 ? `WIN_CHOP_PRE2 : `WIN_CHOP_PRE1;
		else
			rd_win = s.fields.preamble_2 ? `WIN_FULL_PRE2 : `WIN_FULL_PRE1;
	end

	assign wr_active  = wr_en && (wr_tap || s.wr_cnt != 4'h0);
	assign rd_active  = rd_tap || s.rd_cnt != 4'h0;
	assign apb_access = psel_i && penable_i && !s.pready;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		next_s = s;

		// Register slave: one wait state, then a single-cycle pready
		next_s.pready  = 1'b0;
		next_s.pslverr = 1'b0;
		if (apb_access)
		begin
			next_s.pready = 1'b1;
			next_s.prdata = '0;
			case (paddr_i)
				`REG_CFG_FIELDS:
				begin
					if (pwrite_i)
						next_s.fields = cfg_fields_t'({17'h00000, pwdata_i[14:0]});
					else
						next_s.prdata = 32'(s.fields);
				end
				`REG_CFG_LAT:
				begin
					if (pwrite_i)
						next_s.lat = cfg_lat_t'({17'h00000, pwdata_i[14:0]});
					else
						next_s.prdata = 32'(s.lat);
				end
				`REG_STATUS:
				begin
					if (pwrite_i)
						next_s.pslverr = 1'b1;
					else
						next_s.prdata = {16'h0000, s.pin_rx_en, !dll_locked_i, s.strobe_term,
							s.code, s.rd_cnt, s.wr_cnt, s.state};
				end
				default:
					next_s.pslverr = 1'b1;
			endcase
		end

		// Sample pin and commands every edge; a powered-down receiver reads low
		next_s.pin_pipe     = {s.pin_pipe[`PIPE_DEPTH-2:0], rx_on && odt_i};
		next_s.wr_pipe      = {s.wr_pipe[`PIPE_DEPTH-2:0], write_cmd_i && !self_refresh_i};
		next_s.wr_chop_pipe = {s.wr_chop_pipe[`PIPE_DEPTH-2:0], cmd_chop};
		next_s.rd_pipe      = {s.rd_pipe[`PIPE_DEPTH-2:0], read_cmd_i && !self_refresh_i};

		if (wr_tap)
			next_s.wr_cnt = wr_win - 4'h1;
		else if (s.wr_cnt != 4'h0)
			next_s.wr_cnt = s.wr_cnt - 4'h1;

		if (rd_tap)
			next_s.rd_cnt = rd_win - 4'h1;
		else if (s.rd_cnt != 4'h0)
			next_s.rd_cnt = s.rd_cnt - 4'h1;

		// Termination selection by fixed priority
		if (self_refresh_i || !any_en || rd_active)
		begin
			next_s.state = TERM_OFF;
			next_s.code  = 3'h0;
		end
		else if (wr_active)
		begin
			next_s.state = TERM_WRITE;
			next_s.code  = s.fields.write_sel;
		end
		else if (nom_en && nom_tap)
		begin
			next_s.state = TERM_NOMINAL;
			next_s.code  = s.fields.nominal_sel;
		end
		else if (park_en)
		begin
			next_s.state = TERM_PARK;
			next_s.code  = s.fields.park_sel;
		end
		else
		begin
			next_s.state = TERM_OFF;
			next_s.code  = 3'h0;
		end

		next_s.strobe_term = (next_s.state != TERM_OFF) && s.fields.x8_part
			&& s.fields.strobe_en;
		next_s.pin_rx_en = rx_on;
		next_s.active    = next_s.state != TERM_OFF;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s        <= '0;
			s.fields <= cfg_fields_t'(`CFG_FIELDS_RST);
			s.lat    <= cfg_lat_t'(`CFG_LAT_RST);
			s.state  <= TERM_OFF;
		end
		else
			s <= next_s;
	end

	assign prdata_o      = s.prdata;
	assign pready_o      = s.pready;
	assign pslverr_o     = s.pslverr;
	assign term_state_o  = s.state;
	assign term_code_o   = s.code;
	assign term_active_o = s.active;
	assign strobe_term_o = s.strobe_term;
	assign pin_rx_en_o   = s.pin_rx_en;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence seq_rd_load;
		rd_tap && rd_win == 4'h4 && !self_refresh_i;
	endsequence

	sequence seq_rd_window;
		(s.state == TERM_OFF)[*4];
	endsequence

	sr_disable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		self_refresh_i |=> term_state_o == TERM_OFF && !pin_rx_en_o)
		else $error("termination not off in self refresh");

	nom_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!nom_en && $stable(s.fields) |=> term_state_o != TERM_NOMINAL)
		else $error("nominal selected while disabled");

	all_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!any_en |=> !term_active_o)
		else $error("termination active with all fields zero");

	read_prio_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s.rd_cnt != 4'h0 |=> term_state_o == TERM_OFF)
		else $error("termination during read window");

	chop_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		seq_rd_load |=> seq_rd_window)
		else $error("chop read window too short");

	write_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_tap && wr_en && !rd_active && !self_refresh_i |=>
			term_state_o == TERM_WRITE && term_code_o == $past(s.fields.write_sel))
		else $error("write termination not selected");

	nom_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		nom_tap && nom_en && !wr_active && !rd_active && !self_refresh_i |=>
			term_state_o == TERM_NOMINAL)
		else $error("nominal not selected on pin high");

	park_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		term_state_o == TERM_PARK |-> $past(park_en) && !$past(nom_tap && nom_en))
		else $error("park selected wrongly");

	rx_power_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!nom_en && !self_refresh_i ##1 $stable(s.fields) |-> !pin_rx_en_o)
		else $error("pin receiver left on");

	strobe_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		strobe_term_o |-> term_active_o && $past(s.fields.x8_part && s.fields.strobe_en))
		else $error("strobe termination without enable");

	apb_ready_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		apb_access |=> pready_o ##1 !pready_o)
		else $error("bus answer not one cycle");

	apb_err_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		apb_access && pwrite_i && paddr_i == `REG_STATUS |=> pslverr_o && pready_o)
		else $error("status write not refused");

	direct_lat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wl > sub_direct && wl <= sub_direct + 7'h3F |-> 7'(direct_lat) + sub_direct == wl)
		else $error("direct latency wrong");

	read_lat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wl > `SUB_READ && wl <= `SUB_READ + 7'h3F |-> 7'(read_off_lat) + `SUB_READ == wl)
		else $error("read turn-off latency wrong");

	async_lat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!dll_locked_i && nom_en && !self_refresh_i && odt_i ##1 !dll_locked_i && nom_en
			&& !self_refresh_i && !wr_active && !rd_active |=> term_state_o == TERM_NOMINAL)
		else $error("asynchronous nominal late");

	read_tap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_tap |=> !term_active_o)
		else $error("termination on while read data driven");

	sequence seq_full_load;
		rd_tap && rd_win == 4'h6;
	endsequence

	sequence seq_full_window;
		(s.state == TERM_OFF)[*6];
	endsequence

	full_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		seq_full_load |=> seq_full_window)
		else $error("full read window too short");

	code_state_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		term_active_o == (term_code_o != 3'h0))
		else $error("code and active flag disagree");

	nom_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		term_state_o == TERM_NOMINAL |-> term_code_o == $past(s.fields.nominal_sel))
		else $error("nominal code wrong");

	park_code_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		term_state_o == TERM_PARK |-> term_code_o == $past(s.fields.park_sel))
		else $error("park code wrong");

	rx_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		nom_en && !self_refresh_i |=> pin_rx_en_o)
		else $error("pin receiver not powered");

	sr_pipe_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		self_refresh_i |=> !s.pin_pipe[0] && !s.wr_pipe[0] && !s.rd_pipe[0])
		else $error("sample taken in self refresh");

	pin_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!nom_en |=> !s.pin_pipe[0])
		else $error("pin sampled while nominal disabled");

	write_prio_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_active && !rd_active && !self_refresh_i |=> term_state_o == TERM_WRITE)
		else $error("write termination lost priority");

	cnt_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		s.wr_cnt < 4'h8 && s.rd_cnt < 4'h7)
		else $error("window counter out of range");

endmodule

`default_nettype wire

// ### testbench/term_ctrl_model.sv
// Controller-side model: drives the termination pin and the commands.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module term_ctrl_model
#(
	parameter int HOLD_MIN = 6
)
(
	input  wire logic clk_i,
	output logic      odt_o,
	output logic      wr_o,
	output logic      rd_o
);
	initial
	begin
		odt_o = 1'b0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Pin is never held high for less than the minimum hold
	task automatic odt_pulse(input int n);
		odt_o <= 1'b1;
		repeat ((n < HOLD_MIN) ? HOLD_MIN : n) @(posedge clk_i);
		odt_o <= 1'b0;
	endtask
	task automatic cmd(input logic w);
		wr_o <= w;
		rd_o <= !w;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### testbench/term_ctrl_tb.sv
// Bench for the termination control: register access and termination timing.
// Assumes term_ctrl_model on the pin and command side.
`timescale 1ns/100ps
`default_nettype none
`include "term_consts.svh"
module term_ctrl_tb
	import term_pkg::*;
;
	logic        clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, er;
	logic        odt, wr, rdc, sr, dll, strobe, rx, act, chop;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  code;
	term_state_t st_o;
	int          bad_count, n_checks;

	term_ctrl_model mc_u
	(
		.clk_i (clk_i),
		.odt_o (odt),
		.wr_o  (wr),
		.rd_o  (rdc)
	);
	term_ctrl dut_u
	(
		.clk_i          (clk_i),
		.rst_n_i        (rst_n_i),
		.psel_i         (psel),
		.penable_i      (penable),
		.pwrite_i       (pwrite),
		.paddr_i        (paddr),
		.pwdata_i       (pwdata),
		.prdata_o       (prdata),
		.pready_o       (pready),
		.pslverr_o      (pslverr),
		.odt_i          (odt),
		.write_cmd_i    (wr),
		.read_cmd_i     (rdc),
		.chop_i         (chop),
		.self_refresh_i (sr),
		.dll_locked_i   (dll),
		.term_state_o   (st_o),
		.term_code_o    (code),
		.term_active_o  (act),
		.strobe_term_o  (strobe),
		.pin_rx_en_o    (rx)
	);
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do
			@(posedge clk_i);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	// Strobe pair follows the active flag since the part is x8 with strobe on
	task automatic st(input term_state_t s, input logic [2:0] c);
		chk(32'({st_o, code, act, strobe}), 32'({s, c, s != TERM_OFF, s != TERM_OFF}));
	endtask
	task automatic watch(input int l, input int w, input term_state_t ws, input logic [2:0] wc,
		input term_state_t bs, input logic [2:0] bc);
		repeat (l) @(posedge clk_i);
		@(negedge clk_i);
		st(bs, bc);
		repeat (w)
		begin
			@(posedge clk_i);
			@(negedge clk_i);
			st(ws, wc);
		end
		@(posedge clk_i);
		@(negedge clk_i);
		st(bs, bc);
	endtask
	task automatic t_regs();
		@(posedge clk_i);
		apb(1'b0, `REG_CFG_FIELDS, 32'h0);
		chk(rd, `CFG_FIELDS_RST);
		apb(1'b0, `REG_CFG_LAT, 32'h0);
		chk(rd, `CFG_LAT_RST);
		apb(1'b1, `REG_STATUS, 32'h1);
		chk(32'(er), 32'h1);
		apb(1'b0, 12'h00C, 32'h0);
		chk(32'(er), 32'h1);
		apb(1'b1, `REG_CFG_FIELDS, 32'h6099);
		@(negedge clk_i);
		st(TERM_PARK, 3'h2);
		chk(32'(rx), 32'h1);
		@(posedge clk_i);
		apb(1'b0, `REG_STATUS, 32'h0);
		chk(rd, 32'h0000_A803);
		apb(1'b1, `REG_CFG_FIELDS, 32'h2099);
		@(negedge clk_i);
		chk(32'({act, strobe}), 32'h2);
		$display("test regs done");
	endtask
	// k: 0 pin pulse, 1 write, 2 read; l latency, w window
	task automatic t_timing(input logic [31:0] f, input logic [31:0] lt, input int k,
		input int l, input int w);
		term_state_t ws;
		logic [2:0]  wc;
		ws = (k == 0) ? TERM_NOMINAL : (k == 1) ? TERM_WRITE : TERM_OFF;
		wc = (k == 0) ? 3'h1 : (k == 1) ? 3'h3 : 3'h0;
		@(posedge clk_i);
		apb(1'b1, `REG_CFG_FIELDS, f);
		apb(1'b1, `REG_CFG_LAT, lt);
		fork
			if (k == 0)
				mc_u.odt_pulse(w);
			else
				mc_u.cmd(k == 1);
			watch(l, w, ws, wc, TERM_PARK, 3'h2);
		join
		$display("test timing %0d done", k);
	endtask
	task automatic t_prio();
		@(posedge clk_i);
		apb(1'b1, `REG_CFG_FIELDS, 32'h6099);
		fork
			mc_u.odt_pulse(20);
			begin
				repeat (9) @(posedge clk_i);
				fork
					mc_u.cmd(1'b1);
					watch(7, 6, TERM_WRITE, 3'h3, TERM_NOMINAL, 3'h1);
				join
			end
		join
		repeat (12) @(posedge clk_i);
		$display("test priority done");
	endtask
	task automatic t_modes();
		@(posedge clk_i);
		apb(1'b1, `REG_CFG_FIELDS, 32'h6098);
		fork
			mc_u.odt_pulse(6);
			watch(7, 6, TERM_PARK, 3'h2, TERM_PARK, 3'h2);
		join
		chk(32'(rx), 32'h0);
		@(posedge clk_i);
		apb(1'b1, `REG_CFG_FIELDS, 32'h6099);
		sr <= 1'b1;
		@(posedge clk_i);
		@(negedge clk_i);
		st(TERM_OFF, 3'h0);
		chk(32'(rx), 32'h0);
		@(posedge clk_i);
		sr <= 1'b0;
		dll <= 1'b0;
		repeat (2) @(posedge clk_i);
		fork
			mc_u.odt_pulse(6);
			watch(1, 6, TERM_NOMINAL, 3'h1, TERM_PARK, 3'h2);
		join
		@(posedge clk_i);
		dll <= 1'b1;
		$display("test modes done");
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		rst_n_i = 1'b0;
		{psel, penable, pwrite, sr, chop, paddr, pwdata} = '0;
		dll = 1'b1;
		bad_count = 0;
		n_checks = 0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		st(TERM_OFF, 3'h0);
		t_regs();
		t_timing(32'h6099, 32'h9, 0, 7, 6);
		t_timing(32'h6299, 32'h9, 0, 6, 6);
		t_timing(32'h6099, 32'h29, 0, 8, 6);
		t_timing(32'h6099, 32'h9, 1, 7, 6);
		t_timing(32'h7099, 32'h9, 1, 7, 4);
		t_timing(32'h6299, 32'h9, 1, 6, 7);
		t_timing(32'h6499, 32'h9, 1, 7, 7);
		t_timing(32'h6099, 32'h9, 2, 7, 6);
		t_timing(32'h7099, 32'h9, 2, 7, 4);
		t_timing(32'h6299, 32'h9, 2, 7, 7);
		@(posedge clk_i);
		chop <= 1'b1;
		t_timing(32'h6899, 32'h9, 1, 7, 4);
		t_timing(32'h6899, 32'h9, 2, 7, 6);
		@(posedge clk_i);
		chop <= 1'b0;
		t_prio();
		t_modes();
		conclude();
	end
	initial
	begin
		repeat (3000) @(posedge clk_i);
		bad_count++;
		conclude();
	end
endmodule
`default_nettype wire
